/* File: logic/bcc_burst_ctrl.sv */
// Burst read sequencer, read configuration register and prefetch FIFO
`timescale 1ns/1ps

// Prefetch FIFO with registered ready towards the filling side
module bcc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0] count;
  logic [PTR_W:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  // Occupancy after this cycle
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // Pointers, occupancy and ready
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready <= (next_count != (PTR_W + 1)'(DEPTH));
    end
  end

  // Storage
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : bcc_fifo

module bcc_burst_ctrl (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic hw_clear_n,
  input wire logic chip_sel_n,
  input wire logic addr_strobe_n,
  input wire logic out_gate_n,
  input wire logic [bcc_pkg::ADDR_W-1:0] addr_in,
  input wire logic algo_busy,
  input wire logic cmd_valid,
  input wire bcc_pkg::bcc_cmd_s cmd,
  output logic [bcc_pkg::ADDR_W-1:0] arr_addr,
  input wire logic arr_valid,
  output logic arr_ready,
  input wire logic [bcc_pkg::DATA_W-1:0] arr_data,
  output logic [bcc_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe,
  output logic end_of_burst_flag_n,
  output logic end_of_burst_flag_oe
);
  bcc_pkg::bcc_cfg_s cfg;
  bcc_pkg::bcc_state_e state;
  logic strobe_prev_n;
  logic start;
  logic cfg_rd_on;
  logic cfg_rd_bank;
  logic [bcc_pkg::ADDR_W-1:0] start_addr;
  logic [bcc_pkg::ADDR_W-1:0] fetch_addr;
  logic [4:0] lat_cnt;
  logic [2:0] beat;
  logic [2:0] len_mask;
  logic burst_ok;
  logic hit_cfg;
  logic fifo_out_valid;
  logic fifo_pop;
  logic fifo_flush;
  logic [bcc_pkg::DATA_W-1:0] fifo_out_data;
  logic word_take;
  logic drive_word;
  logic flag_hit;
  logic [2:0] flag_beat;
  logic want_word;
  logic use_bypass;
  logic fifo_push;
  logic cfg_word;

  // Start on first sampled edge with select and strobe low
  assign start = hw_clear_n & ~chip_sel_n & ~addr_strobe_n & strobe_prev_n;

  // Burst allowed only with sync mode, linear order, rising edge, data hold off, valid length
  assign burst_ok = ~cfg.read_mode_sel & cfg.burst_order_cfg & cfg.clock_edge_cfg
    & ~cfg.data_hold_cfg
    & ((cfg.burst_length_cfg == bcc_pkg::BLEN_2) | (cfg.burst_length_cfg == bcc_pkg::BLEN_4)
    | (cfg.burst_length_cfg == bcc_pkg::BLEN_8));

  // Wrap mask: 2, 4 or 8 double words
  always_comb begin
    unique case (cfg.burst_length_cfg)
      bcc_pkg::BLEN_2: len_mask = 3'h1;
      bcc_pkg::BLEN_4: len_mask = 3'h3;
      default: len_mask = 3'h7;
    endcase
  end

  // Config read hit on the latched bank
  assign hit_cfg = cfg_rd_on
    & (cfg_rd_bank == (addr_in[bcc_pkg::ADDR_W-1 -: 2] == bcc_pkg::SMALL_BANK_TOP));

  // Flag on final or second-to-last beat
  assign flag_beat = cfg.flag_timing_cfg ? (len_mask - 3'h1) : len_mask;
  assign flag_hit = (beat == flag_beat);

  // Word wanted now; an empty FIFO passes the array word straight through
  assign want_word = ((state == bcc_pkg::BCC_WAIT) & (lat_cnt == 5'h01))
    | (state == bcc_pkg::BCC_BURST);
  assign word_take = arr_valid & arr_ready & (state != bcc_pkg::BCC_IDLE);
  assign use_bypass = want_word & ~fifo_out_valid & word_take;
  assign drive_word = want_word & (fifo_out_valid | word_take);
  assign fifo_pop = want_word & fifo_out_valid;
  // Single reads never queue, so the FIFO cannot fill behind them
  assign fifo_push = word_take & ~use_bypass & (state != bcc_pkg::BCC_SINGLE);
  assign fifo_flush = ~hw_clear_n | chip_sel_n | start | (state == bcc_pkg::BCC_IDLE);

  bcc_fifo #(
    .WIDTH(bcc_pkg::DATA_W),
    .DEPTH(bcc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .flush(fifo_flush),
    .in_valid(fifo_push),
    .in_ready(arr_ready),
    .in_data(arr_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // Strobe history for first-edge detection
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      strobe_prev_n <= 1'b1;
    end else begin
      strobe_prev_n <= addr_strobe_n;
    end
  end

  // Configuration register and bank-selective read mode
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg <= bcc_pkg::CFG_RESET;
      cfg_rd_on <= 1'b0;
      cfg_rd_bank <= 1'b0;
    end else if (!hw_clear_n) begin
      cfg <= bcc_pkg::CFG_RESET;
      cfg_rd_on <= 1'b0;
    end else if (cmd_valid) begin
      if (cmd.op == bcc_pkg::BCC_CMD_CFG_WRITE && !algo_busy) begin
        cfg <= cmd.data;
      end else if (cmd.op == bcc_pkg::BCC_CMD_CFG_READ) begin
        cfg_rd_on <= 1'b1;
        cfg_rd_bank <= cmd.bank;
      end else if (cmd.op == bcc_pkg::BCC_CMD_ARRAY_READ) begin
        cfg_rd_on <= 1'b0;
      end
    end
  end

  // Access sequencer
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= bcc_pkg::BCC_IDLE;
      lat_cnt <= 5'h00;
      start_addr <= '0;
      cfg_word <= 1'b0;
    end else if (!hw_clear_n || chip_sel_n) begin
      state <= bcc_pkg::BCC_IDLE;
    end else if (start) begin
      start_addr <= addr_in;
      cfg_word <= hit_cfg;
      if (burst_ok && !hit_cfg) begin
        state <= bcc_pkg::BCC_WAIT;
        lat_cnt <= {1'b0, cfg.initial_latency_cfg} + bcc_pkg::LATENCY_OFFSET - 5'h01;
      end else begin
        state <= bcc_pkg::BCC_SINGLE;
      end
    end else if (state == bcc_pkg::BCC_WAIT && lat_cnt != 5'h01) begin
      lat_cnt <= lat_cnt - 5'h01;
    end else if (drive_word && state == bcc_pkg::BCC_WAIT) begin
      state <= bcc_pkg::BCC_BURST;
    end
  end

  // Array fetch address, wrapping within the aligned group
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fetch_addr <= '0;
    end else if (start) begin
      fetch_addr <= addr_in;
    end else if (word_take && state != bcc_pkg::BCC_SINGLE) begin
      fetch_addr <= {fetch_addr[bcc_pkg::ADDR_W-1:3],
        (fetch_addr[2:0] & ~len_mask) | ((fetch_addr[2:0] + 3'h1) & len_mask)};
    end
  end

  assign arr_addr = fetch_addr;

  // Beat position within the burst, continues with gate high
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      beat <= 3'h0;
    end else if (start) begin
      beat <= 3'h0;
    end else if (drive_word) begin
      beat <= (beat + 3'h1) & len_mask;
    end
  end

  // Data pins: burst words, single async word or config contents
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dq_out <= '0;
      dq_oe <= 1'b0;
    end else begin
      dq_oe <= 1'b0;
      if (!hw_clear_n || chip_sel_n) begin
        dq_oe <= 1'b0;
      end else begin
        if (drive_word) begin
          dq_out <= fifo_out_valid ? fifo_out_data : arr_data;
        end else if (start && hit_cfg) begin
          dq_out <= {16'h0000, cfg};
        end else if (state == bcc_pkg::BCC_SINGLE && word_take && !cfg_word) begin
          dq_out <= arr_data;
        end
        if (state == bcc_pkg::BCC_BURST || state == bcc_pkg::BCC_SINGLE
          || drive_word || (start && hit_cfg)) begin
          dq_oe <= ~out_gate_n;
        end
      end
    end
  end

  // End-of-burst flag: float with gate high, high until the marked beat
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      end_of_burst_flag_n <= 1'b1;
      end_of_burst_flag_oe <= 1'b0;
    end else if (!hw_clear_n || chip_sel_n || start) begin
      end_of_burst_flag_n <= 1'b1;
      end_of_burst_flag_oe <= 1'b0;
    end else begin
      end_of_burst_flag_oe <= ~out_gate_n
        & (state == bcc_pkg::BCC_WAIT || state == bcc_pkg::BCC_BURST);
      if (drive_word) begin
        end_of_burst_flag_n <= ~flag_hit | out_gate_n;
      end else if (state != bcc_pkg::BCC_BURST) begin
        end_of_burst_flag_n <= 1'b1;
      end
    end
  end
endmodule : bcc_burst_ctrl

/* File: include/bcc_pkg.sv */
// Shared constants, types and register layout for the burst read control block
package bcc_pkg;

  // Bus widths and FIFO depth
  localparam int ADDR_W = 19;
  localparam int DATA_W = 32;
  localparam int CFG_W = 16;
  localparam int FIFO_DEPTH = 16;

  // Read configuration register reset value and field positions
  localparam logic [15:0] CFG_RESET = 16'h9cc4;
  localparam int CFG_READ_MODE_BIT = 15;
  localparam int CFG_LATENCY_LSB = 10;
  localparam int CFG_DATA_HOLD_BIT = 9;
  localparam int CFG_FLAG_TIMING_BIT = 8;
  localparam int CFG_BURST_ORDER_BIT = 7;
  localparam int CFG_CLOCK_EDGE_BIT = 6;
  localparam int CFG_BURST_LEN_LSB = 0;

  // Latency code plus this offset gives the latency in clocks
  localparam logic [4:0] LATENCY_OFFSET = 5'h02;

  // Burst length codes
  localparam logic [2:0] BLEN_2 = 3'h1;
  localparam logic [2:0] BLEN_4 = 3'h2;
  localparam logic [2:0] BLEN_8 = 3'h3;

  // Bank split: upper quarter of the array is the small bank
  localparam logic [1:0] SMALL_BANK_TOP = 2'h3;

  // Configuration register layout
  typedef struct packed {
    logic read_mode_sel;
    logic reserved_14;
    logic [3:0] initial_latency_cfg;
    logic data_hold_cfg;
    logic flag_timing_cfg;
    logic burst_order_cfg;
    logic clock_edge_cfg;
    logic [2:0] reserved_5_3;
    logic [2:0] burst_length_cfg;
  } bcc_cfg_s;

  // Configuration commands
  typedef enum logic [1:0] {
    BCC_CMD_NONE = 2'b00,
    BCC_CMD_CFG_WRITE = 2'b01,
    BCC_CMD_CFG_READ = 2'b10,
    BCC_CMD_ARRAY_READ = 2'b11
  } bcc_cmd_e;

  typedef struct packed {
    bcc_cmd_e op;
    logic bank;
    logic [15:0] data;
  } bcc_cmd_s;

  // Access sequencer states
  typedef enum logic [1:0] {
    BCC_IDLE = 2'b00,
    BCC_WAIT = 2'b01,
    BCC_BURST = 2'b10,
    BCC_SINGLE = 2'b11
  } bcc_state_e;

endpackage : bcc_pkg

/* File: verification/bcc_burst_ctrl_assertions.sv */
// Port checker for the burst read control block
`timescale 1ns/1ps
module bcc_chk (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic hw_clear_n,
  input wire logic chip_sel_n,
  input wire logic out_gate_n,
  input wire logic arr_ready,
  input wire logic dq_oe,
  input wire logic end_of_burst_flag_n,
  input wire logic end_of_burst_flag_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Float and flag relations
  a_clear_float_out: assert property (!hw_clear_n |=> !dq_oe && !end_of_burst_flag_oe)
    else $error("driven after clear");
  a_gate_float_data: assert property (out_gate_n |=> !dq_oe)
    else $error("data driven with gate high");
  a_gate_float_flag: assert property (out_gate_n |=> !end_of_burst_flag_oe)
    else $error("flag driven with gate high");
  a_sel_float_out: assert property (chip_sel_n |=> !dq_oe && !end_of_burst_flag_oe)
    else $error("driven while deselected");
  a_flag_one_cycle: assert property (!end_of_burst_flag_n && end_of_burst_flag_oe
    |=> end_of_burst_flag_n || !end_of_burst_flag_oe)
    else $error("flag low too long");
  a_flag_with_data: assert property (!end_of_burst_flag_n && end_of_burst_flag_oe |-> dq_oe)
    else $error("flag without data");
  a_flag_low_driven: assert property ($fell(end_of_burst_flag_n) |-> end_of_burst_flag_oe)
    else $error("flag low while floating");
  a_idle_fifo_ready: assert property (chip_sel_n [*3] |-> arr_ready)
    else $error("fifo not flushed when idle");
endmodule : bcc_chk
bind bcc_burst_ctrl bcc_chk i_chk (.core_clk, .sys_rst, .hw_clear_n, .chip_sel_n,
  .out_gate_n, .arr_ready, .dq_oe, .end_of_burst_flag_n, .end_of_burst_flag_oe);

/* File: verification/bcc_host_model.sv */
// Host memory controller model issuing reads
`timescale 1ns/1ps
module bcc_host_model (
  input wire logic core_clk,
  output logic chip_sel_n,
  output logic addr_strobe_n,
  output logic out_gate_n,
  output logic [18:0] addr_in
);
  // Idle bus at time zero
  initial begin
    chip_sel_n = 1'b1;
    addr_strobe_n = 1'b1;
    out_gate_n = 1'b1;
    addr_in = '0;
  end
  // One strobe pulse, address dropped after
  task automatic start(input logic [18:0] a);
    @(posedge core_clk);
    #1;
    chip_sel_n = 1'b0;
    out_gate_n = 1'b0;
    addr_strobe_n = 1'b0;
    addr_in = a;
    @(posedge core_clk);
    #1;
    addr_strobe_n = 1'b1;
    addr_in = ~a;
  endtask : start
  task automatic gate(input logic v);
    out_gate_n = v;
  endtask : gate
  // End by deselect, not by gate alone
  task automatic stop();
    chip_sel_n = 1'b1;
    out_gate_n = 1'b1;
  endtask : stop
endmodule : bcc_host_model

/* File: verification/testbench.sv */
// Self-checking bench for the burst read control block
`timescale 1ns/1ps
module testbench;
  typedef struct {
    logic [3:0] lat;
    logic tmg;
    logic [2:0] len;
    logic [18:0] a;
  } bcc_row_s;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hw_clear_n = 1'b1;
  logic algo_busy = 1'b0;
  logic cmd_valid = 1'b0;
  bcc_pkg::bcc_cmd_s cmd = '0;
  logic chip_sel_n, addr_strobe_n, out_gate_n, arr_ready, dq_oe;
  logic end_of_burst_flag_n, end_of_burst_flag_oe;
  logic [18:0] addr_in, arr_addr;
  logic [31:0] dq_out;
  int num_errors = 0;
  int compares = 0;
  bcc_row_s rows [5] = '{'{0, 0, 1, 1}, '{1, 1, 2, 6}, '{3, 0, 3, 5}, '{7, 1, 3, 'h60003},
    '{2, 1, 1, 0}};
  logic [15:0] asyn [3] = '{16'h80c3, 16'h00c0, 16'h00c4};
  bcc_host_model i_host (.core_clk, .chip_sel_n, .addr_strobe_n, .out_gate_n, .addr_in);
  bcc_burst_ctrl i_dut (.core_clk, .sys_rst, .hw_clear_n, .chip_sel_n, .addr_strobe_n,
    .out_gate_n, .addr_in, .algo_busy, .cmd_valid, .cmd, .arr_addr, .arr_valid(1'b1),
    .arr_ready, .arr_data(32'(arr_addr)), .dq_out, .dq_oe, .end_of_burst_flag_n,
    .end_of_burst_flag_oe);
  always #12.5 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    if (num_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  task automatic send(input bcc_pkg::bcc_cmd_e op, input logic b, input logic [15:0] d);
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b1;
    cmd = '{op, b, d};
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
  endtask : send
  task automatic sread(input logic [18:0] a, input logic [31:0] exp);
    i_host.start(a);
    repeat (4) @(posedge core_clk);
    #1;
    chk(dq_out, exp);
    chk(end_of_burst_flag_oe, 1'b0);
    i_host.stop();
  endtask : sread
  task automatic burst(input bcc_row_s r, input bit gap);
    int n;
    logic [18:0] w;
    n = 1 << r.len;
    send(bcc_pkg::BCC_CMD_CFG_WRITE, 1'b0, {2'h0, r.lat, 1'b0, r.tmg, 5'h18, r.len});
    i_host.start(r.a);
    repeat (r.lat) @(posedge core_clk);
    #1;
    chk(dq_oe, 1'b0);
    for (int i = 0; i < 3 * n; i++) begin
      @(posedge core_clk);
      #1;
      w = (r.a & ~19'(n - 1)) | ((r.a + 19'(i)) & 19'(n - 1));
      if (!gap || i > 8) begin
        chk(dq_out, 32'(w));
        chk(dq_oe, 1'b1);
        chk(end_of_burst_flag_n, 32'(i % n != n - 1 - r.tmg));
      end
      if (gap && i inside {[5:6]}) chk(dq_oe, 1'b0);
      if (gap) i_host.gate(i inside {[2:5]});
    end
    i_host.stop();
  endtask : burst
  // Watchdog
  initial begin
    #1000000;
    num_errors++;
    end_sim();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    send(bcc_pkg::BCC_CMD_CFG_READ, 1'b1, 16'h0);
    sread(19'h60000, 32'h9cc4);
    sread(19'h00010, 32'h10);
    algo_busy = 1'b1;
    send(bcc_pkg::BCC_CMD_CFG_WRITE, 1'b0, 16'h00c3);
    algo_busy = 1'b0;
    sread(19'h60000, 32'h9cc4);
    send(bcc_pkg::BCC_CMD_ARRAY_READ, 1'b0, 16'h0);
    foreach (rows[k]) burst(rows[k], 1'b0);
    burst(rows[2], 1'b1);
    foreach (asyn[k]) begin
      send(bcc_pkg::BCC_CMD_CFG_WRITE, 1'b0, asyn[k]);
      sread(19'h00023, 32'h23);
    end
    // Deselect in mid-burst
    send(bcc_pkg::BCC_CMD_CFG_WRITE, 1'b0, 16'h00c3);
    i_host.start(19'h0);
    repeat (3) @(posedge core_clk);
    #1;
    i_host.stop();
    repeat (2) @(posedge core_clk);
    #1;
    chk(dq_oe, 1'b0);
    // Clear in mid-burst restores defaults
    i_host.start(19'h0);
    repeat (3) @(posedge core_clk);
    #1;
    hw_clear_n = 1'b0;
    @(posedge core_clk);
    #1;
    hw_clear_n = 1'b1;
    @(posedge core_clk);
    #1;
    chk(dq_oe, 1'b0);
    chk(end_of_burst_flag_oe, 1'b0);
    i_host.stop();
    send(bcc_pkg::BCC_CMD_CFG_READ, 1'b0, 16'h0);
    sread(19'h00001, 32'h9cc4);
    end_sim();
  end
endmodule : testbench
